/* mcsfr_pkg.sv */
// mcsfr_pkg: constants, register map and carrier types for mcsfr_core.
// assumes a 40 MHz pclk that stands in for the oscillator.
package mcsfr_pkg;

	// machine cycle timing, in oscillator periods
	localparam int OSC_PER_STATE    = 2;
	localparam int STATES_PER_CYCLE = 6;
	localparam int OSC_PER_CYCLE    = OSC_PER_STATE * STATES_PER_CYCLE;
	localparam logic [3:0] POS_LAST   = 4'(OSC_PER_CYCLE - 1);
	localparam logic [3:0] POS_S1P1   = 4'h0;
	localparam logic [3:0] POS_S1P2   = 4'h1;
	localparam logic [3:0] POS_S4P1   = 4'h6;
	localparam logic [3:0] POS_S4P2   = 4'h7;
	localparam logic [3:0] POS_XS_BEG = 4'h2;  // data strobe from S2
	localparam logic [3:0] POS_XS_END = 4'h9;  // to end of S5

	// special register space
	localparam int NUM_SPR = 23;
	localparam logic [7:0] SPR_ADDR [NUM_SPR] = '{
		8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8A,
		8'h8B, 8'h8C, 8'h8D, 8'h90, 8'h91, 8'h93, 8'h94, 8'h95,
		8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'hA0};
	localparam logic [7:0] SPR_RST [NUM_SPR] = '{
		8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
	localparam int SLOT_PTR_LO = 2;  // data pointer low byte slot
	localparam int SLOT_PTR_HI = 3;  // data pointer high byte slot

	// register indexes; byte address is four times the index
	localparam logic [9:0] IDX_SPR_LO = 10'h080;
	localparam logic [9:0] IDX_SPR_HI = 10'h0FF;
	localparam logic [9:0] IDX_CTRL   = 10'h100;
	localparam logic [9:0] IDX_XDATA  = 10'h101;
	localparam logic [9:0] IDX_STAT   = 10'h102;
	localparam logic [9:0] IDX_BITOP  = 10'h103;

	// control register fields
	localparam int CTRL_RUN  = 0;
	localparam int CTRL_OPND = 1;
	localparam int CTRL_XGO  = 2;
	localparam int CTRL_XWR  = 3;
	localparam logic [3:0] CTRL_RST  = 4'h1;
	localparam logic [7:0] XDATA_RST = 8'h00;
	localparam logic [15:0] PC_RST   = 16'h0000;
	localparam int BITOP_VAL = 8;

	typedef enum logic [1:0] {CYC_NORM, CYC_XM1, CYC_XM2} mcsfr_cyc_e;

	// internal core bus towards the memory and logic module
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  dout;
		logic        doe;
		logic        rd_n;
		logic        wr_n;
		logic        code_fetch_strobe_n;
		logic        ale;
		logic        reset_n;
	} mcsfr_bus_s;

endpackage

/* mcsfr_core.sv */
// mcsfr_core: machine-cycle sequencer and special register space,
// with an APB slave for software access.
// assumes the memory and logic module runs on pclk, so its data is
// sampled directly without synchronisers.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module mcsfr_core
	import mcsfr_pkg::*;
(
	input  wire logic        pclk,       // oscillator clock
	input  wire logic        presetn,    // async reset, active low
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb write
	input  wire logic [11:0] paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic      [31:0] prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error
	input  wire logic [7:0]  bus_din,    // core bus data in
	output mcsfr_bus_s       core_bus,   // core bus outputs
	output logic [2:0]       seq_state,  // 0..5 for states one..six
	output logic             seq_phase2  // high in second phase half
);

	// slot lookup over the occupied addresses
	function automatic logic [5:0] slot_of(input logic [7:0] a);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < NUM_SPR; i++) begin
			if (SPR_ADDR[i] == a)
				r = {1'b1, 5'(i)};
		end
		return r;
	endfunction

	logic [7:0]  spr_r [NUM_SPR];
	logic [7:0]  spr_nxt [NUM_SPR];
	logic [3:0]  ctrl_r, ctrl_nxt;
	logic [7:0]  xdata_r, xdata_nxt;
	logic [8:0]  bitop_r, bitop_nxt;
	logic        xpend_r, xpend_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        perr_r, perr_nxt;
	logic [3:0]  pos_r, pos_nxt;
	mcsfr_cyc_e  cyc_r, cyc_nxt;
	logic        xwr_r, xwr_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [7:0]  ir_r, ir_nxt;
	logic [7:0]  opnd_r, opnd_nxt;
	mcsfr_bus_s  bus_r, bus_nxt;
	logic        rstn_r;

	logic [9:0]  idx;
	logic        setup, wr_en;
	logic [5:0]  wslot, bslot;
	logic [7:0]  baddr;
	logic        bit_val;
	logic        run;

	assign idx   = paddr[11:2];
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign wslot = slot_of(idx[7:0]);
	assign run   = ctrl_r[CTRL_RUN];

	// bit address: top five bits pick a register ending in 000
	assign baddr   = {bitop_r[7:3], 3'b000};
	assign bslot   = slot_of(baddr);
	assign bit_val = bslot[5] & bitop_r[7] &
		spr_r[bslot[4:0]][bitop_r[2:0]];

	// zero-wait slave: read data is prepared in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = perr_r;

	assign core_bus   = bus_r;
	assign seq_state  = pos_r[3:1];
	assign seq_phase2 = pos_r[0];

	// register file and apb read path
	always_comb begin
		logic [5:0] s;
		logic [7:0] ba;
		s          = 6'h00;
		ba         = 8'h00;
		spr_nxt    = spr_r;
		ctrl_nxt   = ctrl_r;
		xdata_nxt  = xdata_r;
		bitop_nxt  = bitop_r;
		prdata_nxt = prdata_r;
		perr_nxt   = 1'b0;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			perr_nxt = !((idx >= IDX_SPR_LO && idx <= IDX_SPR_HI) ||
				(idx >= IDX_CTRL && idx <= IDX_BITOP));
			if (idx >= IDX_SPR_LO && idx <= IDX_SPR_HI) begin
				s = slot_of(idx[7:0]);
				// unoccupied: reads give zero, nothing behind it
				if (s[5])
					prdata_nxt[7:0] = spr_r[s[4:0]];
			end else if (idx == IDX_CTRL) begin
				prdata_nxt[3:0] = {ctrl_r[3], xpend_r, ctrl_r[1:0]};
			end else if (idx == IDX_XDATA) begin
				prdata_nxt[7:0] = xdata_r;
			end else if (idx == IDX_STAT) begin
				prdata_nxt = {pc_r, ir_r, 3'b000,
					cyc_r != CYC_NORM, pos_r};
			end else if (idx == IDX_BITOP) begin
				prdata_nxt[8:0] = {bit_val, bitop_r[7:0]};
			end
		end
		if (wr_en) begin
			if (idx >= IDX_SPR_LO && idx <= IDX_SPR_HI &&
				wslot[5])
				spr_nxt[wslot[4:0]] = pwdata[7:0];
			else if (idx == IDX_CTRL)
				ctrl_nxt = {pwdata[CTRL_XWR], 1'b0,
					pwdata[CTRL_OPND], pwdata[CTRL_RUN]};
			else if (idx == IDX_XDATA)
				xdata_nxt = pwdata[7:0];
			else if (idx == IDX_BITOP) begin
				bitop_nxt = pwdata[8:0];
				ba = {pwdata[7:3], 3'b000};
				s = slot_of(ba);
				// bit write only in the upper half, on 000 registers
				if (pwdata[7] && s[5])
					spr_nxt[s[4:0]][pwdata[2:0]] = pwdata[BITOP_VAL];
			end
		end
		// data captured from the bus beats a software write
		if (cyc_r == CYC_XM2 && pos_r == POS_XS_END && !xwr_r)
			xdata_nxt = bus_din;
	end

	// pending move: a new request wins over the clear when taken
	always_comb begin
		logic take;
		take      = xpend_r && pos_r == POS_LAST &&
			cyc_r == CYC_NORM && run;
		xpend_nxt = (xpend_r & ~take) |
			(wr_en && idx == IDX_CTRL && pwdata[CTRL_XGO]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_SPR; i++)
				spr_r[i] <= SPR_RST[i];
			ctrl_r   <= CTRL_RST;
			xdata_r  <= XDATA_RST;
			bitop_r  <= 9'h000;
			xpend_r  <= 1'b0;
			prdata_r <= 32'h0000_0000;
			perr_r   <= 1'b0;
		end else begin
			spr_r    <= spr_nxt;
			ctrl_r   <= ctrl_nxt;
			xdata_r  <= xdata_nxt;
			bitop_r  <= bitop_nxt;
			xpend_r  <= xpend_nxt;
			prdata_r <= prdata_nxt;
			perr_r   <= perr_nxt;
		end
	end

	// sequencer: position 0..11 gives state and phase half
	always_comb begin
		pos_nxt = pos_r;
		cyc_nxt = cyc_r;
		xwr_nxt = xwr_r;
		if (run) begin
			if (pos_r == POS_LAST) begin
				pos_nxt = 4'h0;
				case (cyc_r)
					CYC_NORM: begin
						if (xpend_r) begin
							cyc_nxt = CYC_XM1;
							xwr_nxt = ctrl_r[CTRL_XWR];
						end
					end
					CYC_XM1: cyc_nxt = CYC_XM2;
					CYC_XM2: cyc_nxt = CYC_NORM;
					default: cyc_nxt = CYC_NORM;
				endcase
			end else begin
				pos_nxt = pos_r + 4'h1;
			end
		end
	end

	// fetch path and core bus strobes
	// the bus is registered: its strobes follow the next position and
	// the next cycle kind, while bus_din capture follows the present
	// ones; mixing the two would latch the counter in a move cycle
	always_comb begin
		logic fetch_cyc;
		logic fetch_nxt;
		logic move_nxt;
		logic in_xs;
		fetch_cyc = run && cyc_r != CYC_XM2;
		fetch_nxt = run && cyc_nxt != CYC_XM2;
		move_nxt  = run && cyc_nxt == CYC_XM2;
		in_xs     = pos_r >= POS_XS_BEG && pos_r <= POS_XS_END;
		pc_nxt    = pc_r;
		ir_nxt    = ir_r;
		opnd_nxt  = opnd_r;
		bus_nxt   = bus_r;
		bus_nxt.reset_n             = rstn_r;
		bus_nxt.ale                 = 1'b0;
		bus_nxt.code_fetch_strobe_n = 1'b1;
		bus_nxt.rd_n                = 1'b1;
		bus_nxt.wr_n                = 1'b1;
		bus_nxt.doe                 = 1'b0;
		// two fetches per cycle, address latched in the first half
		if (fetch_nxt) begin
			if (pos_nxt == POS_S1P1 || pos_nxt == POS_S4P1) begin
				bus_nxt.ale  = 1'b1;
				bus_nxt.addr = pc_r;
			end
			if (pos_nxt == POS_S1P2 || pos_nxt == POS_S4P2)
				bus_nxt.code_fetch_strobe_n = 1'b0;
		end
		// opcode taken at the close of state one
		if (fetch_cyc && pos_r == POS_S1P2) begin
			ir_nxt = bus_din;
			pc_nxt = pc_r + 16'h0001;
		end
		// second fetch in state four; byte kept as operand only when CTRL_OPND is set, else dropped
		if (fetch_cyc && pos_r == POS_S4P2 &&
			ctrl_r[CTRL_OPND]) begin
			opnd_nxt = bus_din;
			pc_nxt   = pc_r + 16'h0001;
		end
		// data move cycle addressed by the data pointer
		if (move_nxt) begin
			if (pos_nxt == POS_S1P1) begin
				bus_nxt.ale  = 1'b1;
				bus_nxt.addr = {spr_r[SLOT_PTR_HI], spr_r[SLOT_PTR_LO]};
			end
		end
		// data strobe window of the move cycle
		if (move_nxt && pos_nxt >= POS_XS_BEG &&
			pos_nxt <= POS_XS_END) begin
			bus_nxt.rd_n = xwr_r;
			bus_nxt.wr_n = ~xwr_r;
			bus_nxt.doe  = xwr_r;
			bus_nxt.dout = xdata_r;
		end
		if (in_xs && !run)
			bus_nxt.doe = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r  <= 4'h0;
			cyc_r  <= CYC_NORM;
			xwr_r  <= 1'b0;
			pc_r   <= PC_RST;
			ir_r   <= 8'h00;
			opnd_r <= 8'h00;
			rstn_r <= 1'b0;
			bus_r  <= '{addr: 16'h0000, dout: 8'h00, doe: 1'b0,
				rd_n: 1'b1, wr_n: 1'b1, code_fetch_strobe_n: 1'b1,
				ale: 1'b0, reset_n: 1'b0};
		end else begin
			pos_r  <= pos_nxt;
			cyc_r  <= cyc_nxt;
			xwr_r  <= xwr_nxt;
			pc_r   <= pc_nxt;
			ir_r   <= ir_nxt;
			opnd_r <= opnd_nxt;
			rstn_r <= 1'b1;     // module reset released two edges late, through bus_r
			bus_r  <= bus_nxt;
		end
	end

endmodule // mcsfr_core

`default_nettype wire

/* mcsfr_core_unused.sv */
// mcsfr_core_unused: intentionally empty; all logic lives in mcsfr_core.

/* mcsfr_core_sva.sv */
// mcsfr_core_sva: port checks on sequencer, core bus and apb errors.
// assumes the run bit stays set, so the sequencer never freezes.
`timescale 1ns/100ps
`default_nettype none
module mcsfr_core_sva
	import mcsfr_pkg::*;
(
	input wire logic	pclk,		// clock
	input wire logic	presetn,	// reset, active low
	input wire logic	psel,		// apb select
	input wire logic	penable,	// apb access
	input wire logic [11:0]	paddr,		// apb address
	input wire logic	pslverr,	// apb error
	input wire mcsfr_bus_s	core_bus,	// core bus
	input wire logic [2:0]	seq_state,	// state index
	input wire logic	seq_phase2	// phase half
);
	logic [2:0]	succ_state;
	logic		armed_r;
	// armed one edge after release: the release edge itself still
	// resets the design, so checks started there would misfire
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			armed_r <= 1'b0;
		else
			armed_r <= 1'b1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !armed_r);
	// successor state, wrapping after state six
	assign succ_state = (seq_state == 3'h5) ? 3'h0 : seq_state + 3'h1;
	// a fetch slot is one low period of the strobe
	sequence fetch_s;
		!core_bus.code_fetch_strobe_n ##1 core_bus.code_fetch_strobe_n;
	endsequence
	// a move slot skips the fetch and opens a data strobe
	sequence move_s;
		core_bus.code_fetch_strobe_n ##1 !(core_bus.rd_n && core_bus.wr_n);
	endsequence
	state_step_a: assert property (seq_phase2 |=>
		!seq_phase2 && seq_state == $past(succ_state))
		else $error("state step wrong");
	phase_half_a: assert property (!seq_phase2 |=>
		seq_phase2 && $stable(seq_state)) else $error("phase half wrong");
	latch_slot_a: assert property (core_bus.ale |->
		!seq_phase2 && seq_state inside {3'h0, 3'h3})
		else $error("latch strobe outside slot");
	fetch_slot_a: assert property (!core_bus.code_fetch_strobe_n |->
		seq_phase2 && seq_state inside {3'h0, 3'h3})
		else $error("fetch strobe outside slot");
	slot_use_a: assert property (core_bus.ale |=> fetch_s or move_s)
		else $error("latch not followed by fetch or move");
	move_window_a: assert property (!(core_bus.rd_n && core_bus.wr_n) |->
		core_bus.code_fetch_strobe_n && seq_state inside {[3'h1:3'h4]})
		else $error("data strobe outside window");
	move_length_a: assert property ($fell(core_bus.rd_n) |->
		!core_bus.rd_n [*8] ##1 core_bus.rd_n) else $error("read length");
	write_drive_a: assert property (!core_bus.wr_n |->
		core_bus.doe && $stable(core_bus.addr)) else $error("write drive");
	map_error_a: assert property (psel && penable |-> pslverr ==
		(paddr[11:2] < 10'h080 || paddr[11:2] > 10'h103))
		else $error("error flag wrong");
endmodule // mcsfr_core_sva
bind mcsfr_core mcsfr_core_sva i_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
	.core_bus(core_bus), .seq_state(seq_state), .seq_phase2(seq_phase2));
`default_nettype wire

/* mcsfr_mem_model.sv */
// mcsfr_mem_model: memory and logic module on the core bus.
// assumes the core holds addr steady through every strobe.
`timescale 1ns/100ps
`default_nettype none
module mcsfr_mem_model
	import mcsfr_pkg::*;
(
	input wire logic	pclk,		// clock
	input wire mcsfr_bus_s	core_bus,	// bus from the core
	output logic [7:0]	bus_din,	// data to the core
	output logic [15:0]	wr_addr,	// last write address
	output logic [7:0]	wr_byte		// last write data
);
	logic [7:0]	last_r = 8'h00;
	// released bus shows the inverse of its last value, not a copy
	always_comb begin
		if (!core_bus.code_fetch_strobe_n)
			bus_din = core_bus.addr[7:0] ^ 8'h3C;
		else if (!core_bus.rd_n)
			bus_din = core_bus.addr[7:0] ^ 8'h5A;
		else
			bus_din = ~last_r;
	end
	// track bus value and capture driven writes
	always_ff @(posedge pclk) begin
		last_r <= bus_din;
		if (!core_bus.wr_n && core_bus.doe) begin
			wr_addr <= core_bus.addr;
			wr_byte <= core_bus.dout;
		end
	end
endmodule // mcsfr_mem_model
`default_nettype wire

/* test_mcsfr_core.sv */
// test_mcsfr_core: apb-driven bench for mcsfr_core.
// assumes mcsfr_mem_model stands on the core bus.
`timescale 1ns/100ps
`default_nettype none
module test_mcsfr_core;
	import mcsfr_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, pready;
	logic		pslverr, seq_phase2, err_w;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rd_w;
	logic [7:0]	bus_din, wr_byte;
	logic [15:0]	wr_addr, pc0;
	logic [2:0]	seq_state;
	mcsfr_bus_s	core_bus;
	int		failures, samples_checked;
	mcsfr_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_din(bus_din), .core_bus(core_bus),
		.seq_state(seq_state), .seq_phase2(seq_phase2));
	mcsfr_mem_model i_mem (.pclk(pclk), .core_bus(core_bus),
		.bus_din(bus_din), .wr_addr(wr_addr), .wr_byte(wr_byte));
	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			wrap_up();
		end
		rd_w = prdata;
		err_w = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [9:0] idx,
		input logic [31:0] exp);
		apb_xfer(1'b0, idx, 32'h0);
		chk(nm, exp, rd_w);
	endtask
	// opcode must match the byte fetched before the counter moved
	task automatic stat_chk(input logic opnd);
		logic [15:0] back;
		apb_xfer(1'b0, IDX_STAT, 32'h0);
		back = (opnd && (rd_w[3:0] < 4'h2 || rd_w[3:0] > 4'h7)) ?
			16'h0002 : 16'h0001;
		chk("opcode", {24'h0, (rd_w[23:16] - back[7:0]) ^ 8'h3C},
			{24'h0, rd_w[15:8]});
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		failures = 0;
		samples_checked = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (SPR_ADDR[i])
			rd_chk("reset", {2'b00, SPR_ADDR[i]}, {24'h0, SPR_RST[i]});
		rd_chk("ctrl", IDX_CTRL, {28'h0, CTRL_RST});
		foreach (SPR_ADDR[i])
			apb_xfer(1'b1, {2'b00, SPR_ADDR[i]}, {24'h0, ~SPR_ADDR[i]});
		foreach (SPR_ADDR[i])
			rd_chk("reg", {2'b00, SPR_ADDR[i]}, {24'h0, ~SPR_ADDR[i]});
		apb_xfer(1'b1, IDX_BITOP, 32'h18F);
		apb_xfer(1'b1, IDX_BITOP, 32'h088);
		rd_chk("bit", IDX_BITOP, 32'h088);
		rd_chk("bit reg", 10'h088, 32'hF6);
		apb_xfer(1'b1, 10'h085, 32'h0);
		apb_xfer(1'b1, 10'h084, 32'hFF);
		rd_chk("hole", 10'h084, 32'h0);
		chk("hole err", 32'h0, {31'h0, err_w});
		rd_chk("outside", 10'h104, 32'h0);
		chk("outside err", 32'h1, {31'h0, err_w});
		for (int k = 0; k < 2; k++) begin
			apb_xfer(1'b1, IDX_CTRL, 32'(1 + 2 * k));
			apb_xfer(1'b0, IDX_STAT, 32'h0);
			pc0 = rd_w[31:16];
			repeat (9) @(posedge pclk);
			apb_xfer(1'b0, IDX_STAT, 32'h0);
			chk("pc step", {16'h0, pc0 + 16'(k + 1)}, {16'h0, rd_w[31:16]});
			repeat (4) stat_chk(k[0]);
		end
		apb_xfer(1'b1, 10'h083, 32'h12);
		apb_xfer(1'b1, 10'h082, 32'h34);
		apb_xfer(1'b1, IDX_XDATA, 32'hA7);
		apb_xfer(1'b1, IDX_CTRL, 32'hD);
		for (int n = 0; n < 60 && wr_byte !== 8'hA7; n++)
			@(posedge pclk);
		chk("move addr", 32'h1234, {16'h0, wr_addr});
		chk("move data", 32'hA7, {24'h0, wr_byte});
		apb_xfer(1'b1, IDX_CTRL, 32'h5);
		for (int n = 0; n < 30 && rd_w !== 32'h6E; n++)
			apb_xfer(1'b0, IDX_XDATA, 32'h0);
		chk("move read", 32'h6E, rd_w);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd_chk("rereset", 10'h081, 32'h07);
		wrap_up();
	end
endmodule // test_mcsfr_core
`default_nettype wire
